/* verilog/pbc_pkg.sv */
// pbc_pkg: constants for the basic phy control register block.
// assumes a 200 MHz core clock and a 16-bit management register port.
package pbc_pkg;

	// clock figures
	localparam int CLK_PERIOD_PS = 5000;

	// soft reset duration, least time, rounded up to whole cycles
	localparam int SRST_TIME_NS = 1000;
	localparam int SRST_CYC =
		(SRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SRST_CNT_W = $clog2(SRST_CYC + 1);

	// register map
	localparam logic [4:0] REG_BASIC_CTRL = 5'h00;

	// field positions of basic_phy_control
	localparam int F_SRST = 15;
	localparam int F_LPBK = 14;
	localparam int F_SPD = 13;
	localparam int F_ANEN = 12;
	localparam int F_LPWR = 11;
	localparam int F_ISO = 10;
	localparam int F_ANRS = 9;
	localparam int F_DPX = 8;
	localparam int F_CTST = 7;

	// reset value; isolate is filled from the address strap
	localparam logic [15:0] CTRL_RST = 16'h3000;
	// writable bits; reserved 6:0 stay zero
	localparam logic [15:0] CTRL_WMASK = 16'hff80;

	// pin synchroniser width: txd(4) tx_en addr(5) dpx an spd cfg
	localparam int SYNC_W = 14;

	// control sequencer
	typedef enum logic {
		PBC_IDLE = 1'b0,
		PBC_SRST = 1'b1
	} pbc_state_t;

endpackage

/* verilog/pbc_ctrl.sv */
// pbc_ctrl: basic phy control register with mode resolution and the
// mac-side loopback, collision test, isolate and low-power gating.
// assumes a management frame engine delivering register accesses on
// core_clk, and an autoneg engine plus pma datapath on the same clock.
`timescale 1ns/1ps

module pbc_ctrl
	import pbc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// management register port
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	input wire logic [4:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rvalid,
	// strap and select pins
	input wire logic config_source_strap,
	input wire logic speed_select_pin,
	input wire logic autoneg_select_pin,
	input wire logic duplex_select_pin,
	input wire logic [4:0] phy_addr_strap,
	// autoneg engine
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	input wire logic an_restart_ack,
	output logic an_enable,
	output logic an_restart,
	// resolved modes and internal control
	output logic speed_100,
	output logic full_duplex,
	output logic loopback_en,
	output logic low_power,
	output logic core_reset,
	output logic latch_status_reinit,
	// mac side pins
	input wire logic mac_tx_en,
	input wire logic [3:0] mac_txd,
	output logic mac_rx_dv,
	output logic [3:0] mac_rxd,
	output logic mac_crs,
	output logic mac_col,
	output logic mac_out_oe_n,
	// line side datapath
	input wire logic line_rx_dv,
	input wire logic [3:0] line_rxd,
	input wire logic line_crs,
	input wire logic line_col,
	output logic line_tx_en,
	output logic [3:0] line_txd,
	output logic twisted_pair_tristate
);

	// pin synchronisers, two flops per bit
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] sync_q;
	assign pin_raw = {mac_txd, mac_tx_en, phy_addr_strap,
		duplex_select_pin, autoneg_select_pin, speed_select_pin,
		config_source_strap};
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge core_clk) begin
				meta_q[gi] <= pin_raw[gi];
				sync_q[gi] <= meta_q[gi];
			end
		end
	endgenerate

	logic cfg_s;
	logic spd_pin_s;
	logic an_pin_s;
	logic dpx_pin_s;
	logic [4:0] addr_s;
	logic tx_en_s;
	logic [3:0] txd_s;
	assign cfg_s = sync_q[0];
	assign spd_pin_s = sync_q[1];
	assign an_pin_s = sync_q[2];
	assign dpx_pin_s = sync_q[3];
	assign addr_s = sync_q[8:4];
	assign tx_en_s = sync_q[9];
	assign txd_s = sync_q[13:10];

	// register state
	pbc_state_t state_q, state_d;
	logic [15:0] ctrl_q, ctrl_d;
	logic [SRST_CNT_W-1:0] cnt_q, cnt_d;
	logic iso_load_q, iso_load_d;
	logic [15:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic lp_prev_q;
	logic reinit_q, reinit_d;
	logic wr_hit;
	logic new_an;

	assign wr_hit = mgmt_wr && (mgmt_addr == REG_BASIC_CTRL);

	// register next state; writes during soft reset are dropped
	always_comb begin
		state_d = state_q;
		ctrl_d = ctrl_q;
		cnt_d = cnt_q;
		iso_load_d = 1'b0;
		new_an = 1'b0;
		if (iso_load_q)
			ctrl_d[F_ISO] = (addr_s == 5'h00);
		unique case (state_q)
			PBC_IDLE: begin
				if (an_restart_ack)
					ctrl_d[F_ANRS] = 1'b0;
				if (wr_hit) begin
					ctrl_d = mgmt_wdata & CTRL_WMASK;
					new_an = cfg_s ? mgmt_wdata[F_ANEN] : an_pin_s;
					// set wins over a same-cycle ack clear
					ctrl_d[F_ANRS] = mgmt_wdata[F_ANRS] && new_an;
					if (mgmt_wdata[F_SRST]) begin
						state_d = PBC_SRST;
						ctrl_d = CTRL_RST;
						ctrl_d[F_SRST] = 1'b1;
						cnt_d = SRST_CNT_W'(SRST_CYC - 1);
						iso_load_d = 1'b1;
					end
				end
			end
			PBC_SRST: begin
				cnt_d = cnt_q - 1'b1;
				if (cnt_q == '0) begin
					state_d = PBC_IDLE;
					ctrl_d[F_SRST] = 1'b0;
				end
			end
		endcase
	end

	// register flops; power-on reset also loads isolate from strap
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_q <= PBC_IDLE;
			ctrl_q <= CTRL_RST;
			cnt_q <= '0;
			iso_load_q <= 1'b1;
		end else begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			cnt_q <= cnt_d;
			iso_load_q <= iso_load_d;
		end
	end

	// read port; unmapped addresses read zero
	always_comb begin
		rdata_d = rdata_q;
		rvalid_d = mgmt_rd;
		if (mgmt_rd)
			rdata_d = (mgmt_addr == REG_BASIC_CTRL) ? ctrl_q : 16'h0000;
	end

	// low-power entry edge clears latching status elsewhere
	always_comb begin
		reinit_d = ctrl_q[F_LPWR] && !lp_prev_q;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
			lp_prev_q <= 1'b0;
			reinit_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			lp_prev_q <= ctrl_q[F_LPWR];
			reinit_q <= reinit_d;
		end
	end

	// mode resolution and mac/line datapath gating
	logic srst;
	logic lpbk;
	logic lpwr;
	logic iso;
	logic ctst;
	logic tx_en_eff;
	logic [3:0] txd_eff;
	logic an_en_c;
	logic spd_d, dpx_d;
	logic rx_dv_d, crs_d, col_d;
	logic [3:0] rxd_d, ltxd_d;
	logic ltx_en_d, tri_d;
	logic spd_q, dpx_q, anen_q, anrs_q;
	logic rx_dv_q, crs_q, col_q, oe_n_q;
	logic [3:0] rxd_q, ltxd_q;
	logic ltx_en_q, tri_q;

	assign srst = (state_q == PBC_SRST);
	assign lpbk = ctrl_q[F_LPBK];
	assign lpwr = ctrl_q[F_LPWR];
	assign iso = ctrl_q[F_ISO];
	assign ctst = ctrl_q[F_CTST];
	assign tx_en_eff = tx_en_s && !iso;
	assign txd_eff = iso ? 4'h0 : txd_s;

	always_comb begin
		an_en_c = cfg_s ? ctrl_q[F_ANEN] : an_pin_s;
		if (!cfg_s) begin
			spd_d = spd_pin_s;
			dpx_d = dpx_pin_s;
		end else if (ctrl_q[F_ANEN]) begin
			spd_d = an_speed_100;
			dpx_d = an_full_duplex;
		end else begin
			spd_d = ctrl_q[F_SPD];
			dpx_d = ctrl_q[F_DPX];
		end
		// loopback needs no carrier deference, so duplex is moot
		if (lpbk)
			dpx_d = 1'b1;
		rx_dv_d = line_rx_dv;
		rxd_d = line_rxd;
		crs_d = line_crs;
		col_d = line_col;
		ltx_en_d = tx_en_eff;
		ltxd_d = txd_eff;
		tri_d = 1'b0;
		if (lpbk) begin
			// one flop after the synchroniser keeps this far under 512
			rx_dv_d = tx_en_eff;
			rxd_d = txd_eff;
			crs_d = tx_en_eff;
			col_d = 1'b0;
			ltx_en_d = 1'b0;
			ltxd_d = 4'h0;
			tri_d = 1'b1;
		end
		if (ctst)
			col_d = tx_en_eff;
		else if (!lpbk)
			col_d = line_col;
		if (lpwr || srst) begin
			rx_dv_d = 1'b0;
			rxd_d = 4'h0;
			crs_d = 1'b0;
			col_d = 1'b0;
			ltx_en_d = 1'b0;
			ltxd_d = 4'h0;
			tri_d = lpwr;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			spd_q <= 1'b0;
			dpx_q <= 1'b0;
			anen_q <= 1'b0;
			anrs_q <= 1'b0;
			rx_dv_q <= 1'b0;
			rxd_q <= 4'h0;
			crs_q <= 1'b0;
			col_q <= 1'b0;
			oe_n_q <= 1'b1;
			ltx_en_q <= 1'b0;
			ltxd_q <= 4'h0;
			tri_q <= 1'b0;
		end else begin
			spd_q <= spd_d;
			dpx_q <= dpx_d;
			anen_q <= an_en_c;
			anrs_q <= ctrl_q[F_ANRS] && !srst;
			rx_dv_q <= rx_dv_d;
			rxd_q <= rxd_d;
			crs_q <= crs_d;
			col_q <= col_d;
			oe_n_q <= iso;
			ltx_en_q <= ltx_en_d;
			ltxd_q <= ltxd_d;
			tri_q <= tri_d;
		end
	end

	// outputs
	assign mgmt_rdata = rdata_q;
	assign mgmt_rvalid = rvalid_q;
	assign an_enable = anen_q;
	assign an_restart = anrs_q;
	assign speed_100 = spd_q;
	assign full_duplex = dpx_q;
	assign loopback_en = lpbk;
	assign low_power = lpwr;
	assign core_reset = srst;
	assign latch_status_reinit = reinit_q;
	assign mac_rx_dv = rx_dv_q;
	assign mac_rxd = rxd_q;
	assign mac_crs = crs_q;
	assign mac_col = col_q;
	assign mac_out_oe_n = oe_n_q;
	assign line_tx_en = ltx_en_q;
	assign line_txd = ltxd_q;
	assign twisted_pair_tristate = tri_q;

	// checks
	property p_srst_hold;
		@(posedge core_clk) disable iff (!resetn)
		$rose(srst) |-> (srst && ctrl_q[F_SRST]) [*8];
	endproperty
	a_srst_hold: assert property (p_srst_hold)
		else $error("soft reset bit dropped early");

	property p_srst_end;
		@(posedge core_clk) disable iff (!resetn)
		$fell(srst) |-> (ctrl_q & 16'hfbff) == CTRL_RST;
	endproperty
	a_srst_end: assert property (p_srst_end)
		else $error("soft reset left non-default bits");

	property p_rsvd;
		@(posedge core_clk) disable iff (!resetn)
		mgmt_rvalid |-> mgmt_rdata[6:0] == 7'h00;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bits read non-zero");

	property p_hw_speed;
		@(posedge core_clk) disable iff (!resetn)
		!cfg_s |=> speed_100 == $past(spd_pin_s);
	endproperty
	a_hw_speed: assert property (p_hw_speed)
		else $error("hardware speed not from pin");

	property p_sw_an;
		@(posedge core_clk) disable iff (!resetn)
		cfg_s && ctrl_q[F_ANEN] && !lpbk |=>
			speed_100 == $past(an_speed_100) &&
			full_duplex == $past(an_full_duplex);
	endproperty
	a_sw_an: assert property (p_sw_an)
		else $error("autoneg result not used");

	property p_rs_ignore;
		@(posedge core_clk) disable iff (!resetn)
		wr_hit && !srst && cfg_s && !mgmt_wdata[F_ANEN] |=>
			!ctrl_q[F_ANRS];
	endproperty
	a_rs_ignore: assert property (p_rs_ignore)
		else $error("restart kept with autoneg off");

	sequence s_col_cause;
		ctst && tx_en_eff && !lpwr && !srst;
	endsequence
	property p_col_test;
		@(posedge core_clk) disable iff (!resetn)
		s_col_cause |=> mac_col;
	endproperty
	a_col_test: assert property (p_col_test)
		else $error("collision test col missing");

	property p_lpbk_col;
		@(posedge core_clk) disable iff (!resetn)
		lpbk && !ctst |=> !mac_col;
	endproperty
	a_lpbk_col: assert property (p_lpbk_col)
		else $error("col active in loopback");

	property p_iso;
		@(posedge core_clk) disable iff (!resetn)
		iso |=> mac_out_oe_n && !line_tx_en && line_txd == 4'h0;
	endproperty
	a_iso: assert property (p_iso)
		else $error("isolate not honoured");

	property p_lp;
		@(posedge core_clk) disable iff (!resetn)
		lpwr |=> !mac_rx_dv && !mac_col && !line_tx_en &&
			twisted_pair_tristate;
	endproperty
	a_lp: assert property (p_lp)
		else $error("low power outputs not quiet");

endmodule // pbc_ctrl

/* tb/pbc_an_model.sv */
// pbc_an_model: autoneg engine stand-in facing the control block.
// assumes it shares core_clk and resetn with the block under test.
`timescale 1ns/1ps

module pbc_an_model #(
	parameter logic RES_SPD = 1'b1,
	parameter logic RES_DPX = 1'b1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// control block side
	input wire logic an_enable,
	input wire logic an_restart,
	input wire logic [3:0] ack_dly,
	output logic an_restart_ack,
	output logic an_speed_100,
	output logic an_full_duplex
);
	logic [3:0] wait_q;
	logic busy_q;

	// results are only meaningful while negotiation runs
	assign an_speed_100 = an_enable ? RES_SPD : ~RES_SPD;
	assign an_full_duplex = an_enable ? RES_DPX : ~RES_DPX;

	// one ack per request, after a delay set by the bench
	always_ff @(posedge core_clk) begin
		an_restart_ack <= 1'b0;
		if (!resetn) begin
			wait_q <= 4'h0;
			busy_q <= 1'b0;
		end else if (an_restart && !busy_q) begin
			if (wait_q == ack_dly) begin
				an_restart_ack <= 1'b1;
				busy_q <= 1'b1;
			end
			wait_q <= wait_q + 4'h1;
		end else if (!an_restart) begin
			wait_q <= 4'h0;
			busy_q <= 1'b0;
		end
	end
endmodule // pbc_an_model

/* tb/pbc_ctrl_bench.sv */
// pbc_ctrl_bench: self-checking bench for the basic control register.
// assumes pbc_pkg, pbc_ctrl and the autoneg model are compiled first.
`timescale 1ns/1ps

module pbc_ctrl_bench import pbc_pkg::*;;
	logic core_clk, resetn, mgmt_wr, mgmt_rd, mgmt_rvalid;
	logic [4:0] mgmt_addr, phy_addr_strap;
	logic [15:0] mgmt_wdata, mgmt_rdata;
	logic config_source_strap, speed_select_pin, autoneg_select_pin;
	logic duplex_select_pin, an_speed_100, an_full_duplex, an_restart_ack;
	logic an_enable, an_restart, speed_100, full_duplex, loopback_en;
	logic low_power, core_reset, latch_status_reinit, mac_tx_en;
	logic mac_rx_dv, mac_crs, mac_col, mac_out_oe_n, line_tx_en;
	logic twisted_pair_tristate, line_rx_dv, line_crs, line_col;
	logic [3:0] mac_txd, mac_rxd, line_txd, ack_dly, line_rxd;
	int checks = 0;
	int errors = 0;

	// line side driven busy where loopback and low power must mask it
	pbc_ctrl dut_u (.core_clk, .resetn, .mgmt_wr, .mgmt_rd, .mgmt_addr,
		.mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .config_source_strap,
		.speed_select_pin, .autoneg_select_pin, .duplex_select_pin,
		.phy_addr_strap, .an_speed_100, .an_full_duplex, .an_restart_ack,
		.an_enable, .an_restart, .speed_100, .full_duplex, .loopback_en,
		.low_power, .core_reset, .latch_status_reinit, .mac_tx_en,
		.mac_txd, .mac_rx_dv, .mac_rxd, .mac_crs, .mac_col, .mac_out_oe_n,
		.line_rx_dv, .line_rxd, .line_crs, .line_col, .line_tx_en,
		.line_txd, .twisted_pair_tristate);

	pbc_an_model an_u (.core_clk, .resetn, .an_enable, .an_restart,
		.ack_dly, .an_restart_ack, .an_speed_100, .an_full_duplex);

	// 200 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic test_done();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// inputs always move 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic hard_reset(input logic [4:0] pa);
		resetn = 1'b0;
		phy_addr_strap = pa;
		tick(5);
		resetn = 1'b1;
		tick(2);
	endtask

	// extra edge at the end so the strobe never toggles twice in a step
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		mgmt_wr = 1'b1;
		mgmt_addr = a;
		mgmt_wdata = d;
		tick(1);
		mgmt_wr = 1'b0;
		tick(1);
	endtask

	task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
		int i;
		mgmt_rd = 1'b1;
		mgmt_addr = a;
		tick(1);
		mgmt_rd = 1'b0;
		for (i = 0; i < 4 && mgmt_rvalid !== 1'b1; i++)
			tick(1);
		if (mgmt_rvalid !== 1'b1) begin
			errors++;
			test_done();
		end
		check(mgmt_rdata, exp);
		tick(1);
	endtask

	initial begin
		int i;
		logic seen;
		{mgmt_wr, mgmt_rd, mac_tx_en, speed_select_pin} = 4'h0;
		{autoneg_select_pin, duplex_select_pin} = 2'h0;
		{line_rx_dv, line_crs, line_col} = 3'h0;
		line_rxd = 4'h0;
		config_source_strap = 1'b1;
		mgmt_addr = 5'h00;
		mgmt_wdata = 16'h0000;
		mac_txd = 4'ha;
		ack_dly = 4'h1;
		hard_reset(5'h00);
		rchk(REG_BASIC_CTRL, 16'h3400);
		hard_reset(5'h05);
		rchk(REG_BASIC_CTRL, 16'h3000);
		wr_reg(5'h01, 16'hffff);
		rchk(5'h01, 16'h0000);
		rchk(REG_BASIC_CTRL, 16'h3000);
		// software mode: autoneg result, then register bits
		check({an_enable, speed_100, full_duplex}, 3'h7);
		wr_reg(REG_BASIC_CTRL, 16'h0000);
		tick(4);
		check({an_enable, speed_100, full_duplex}, 3'h0);
		wr_reg(REG_BASIC_CTRL, 16'h2100);
		tick(4);
		check({an_enable, speed_100, full_duplex}, 3'h3);
		wr_reg(REG_BASIC_CTRL, 16'h0200);
		rchk(REG_BASIC_CTRL, 16'h0000);
		// slow engine: restart bit holds until negotiation begins
		ack_dly = 4'ha;
		wr_reg(REG_BASIC_CTRL, 16'h1200);
		rchk(REG_BASIC_CTRL, 16'h1200);
		check(an_restart, 1'b1);
		tick(12);
		rchk(REG_BASIC_CTRL, 16'h1000);
		check(an_restart, 1'b0);
		// loopback with reserved bits written as ones
		wr_reg(REG_BASIC_CTRL, 16'h407f);
		rchk(REG_BASIC_CTRL, 16'h4000);
		{line_rx_dv, line_crs, line_col} = 3'h7;
		line_rxd = 4'h5;
		mac_tx_en = 1'b1;
		tick(4);
		check({mac_rx_dv, mac_crs, mac_rxd}, 6'h3a);
		check({line_tx_en, mac_col, full_duplex}, 3'h1);
		mac_tx_en = 1'b0;
		wr_reg(REG_BASIC_CTRL, 16'h4080);
		mac_tx_en = 1'b1;
		tick(4);
		check(mac_col, 1'b1);
		mac_tx_en = 1'b0;
		tick(4);
		check(mac_col, 1'b0);
		// isolate: outputs released, inputs ignored, management alive
		wr_reg(REG_BASIC_CTRL, 16'h0400);
		mac_tx_en = 1'b1;
		tick(4);
		check({mac_out_oe_n, line_tx_en}, 2'h2);
		check({mac_col, mac_rxd, line_txd}, 9'h150);
		rchk(REG_BASIC_CTRL, 16'h0400);
		// low power keeps the register, pulses the latch reinit
		wr_reg(REG_BASIC_CTRL, 16'h0800);
		seen = 1'b0;
		for (i = 0; i < 4; i++) begin
			if (latch_status_reinit === 1'b1)
				seen = 1'b1;
			tick(1);
		end
		check(seen, 1'b1);
		check({low_power, twisted_pair_tristate, mac_rx_dv, mac_col,
			line_tx_en}, 5'h18);
		rchk(REG_BASIC_CTRL, 16'h0800);
		mac_tx_en = 1'b0;
		{line_rx_dv, line_crs, line_col} = 3'h0;
		line_rxd = 4'h0;
		// hardware mode: pins decide, register bits ignored
		config_source_strap = 1'b0;
		wr_reg(REG_BASIC_CTRL, 16'h1100);
		for (i = 0; i < 4; i++) begin
			{speed_select_pin, duplex_select_pin} = i[1:0];
			tick(4);
			check({an_enable, speed_100, full_duplex}, i[1:0]);
		end
		autoneg_select_pin = 1'b1;
		tick(4);
		check(an_enable, 1'b1);
		autoneg_select_pin = 1'b0;
		config_source_strap = 1'b1;
		// soft reset: bit reads one, writes refused, then defaults
		wr_reg(REG_BASIC_CTRL, 16'h8000);
		check(core_reset, 1'b1);
		rchk(REG_BASIC_CTRL, 16'hb000);
		wr_reg(REG_BASIC_CTRL, 16'h4000);
		for (i = 0; i < 400 && core_reset === 1'b1; i++)
			tick(1);
		check({core_reset, loopback_en, i > SRST_CYC - 10}, 3'h1);
		rchk(REG_BASIC_CTRL, 16'h3000);
		test_done();
	end
endmodule // pbc_ctrl_bench
